/* sim/ddr_burst4_cio_sram_port_test.sv */
// bench top: writes and reads through the controller model, checks data and timing
// assumes design files, checker and controller model compiled first
`default_nettype none
`include "sram_port_consts.svh"

`define CHK(what, exp, got) \
    begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end

module ddr_burst4_cio_sram_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 8;
    localparam int DW = 36;
    localparam int NB = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic dll_enable = 1'b1;
    logic impedance_ref_pin = 1'b1;
    logic k_in, k_n_in, load_strobe_n, rw_sel;
    logic [AW-1:0] burst_address_in;
    logic [DW-1:0] dq_in, dq_out;
    logic [NB-1:0] byte_lane_write_n;
    logic dq_oe, echo_clock_true, echo_clock_comp, read_valid_flag, impedance_ready;
    logic [`IMP_W-1:0] impedance_code;
    logic [DW-1:0] mem [0:(1<<AW)-1];
    int comparisons = 0;
    int miscompares = 0;

    mem_ctl_model #(.AW(AW), .DW(DW), .NB(NB)) ctl_u (.ref_clk, .k_in, .k_n_in, .load_strobe_n,
        .rw_sel, .burst_address_in, .dq_in, .byte_lane_write_n);
    ddr_burst4_cio_sram_port #(.AW(AW), .DW(DW), .NB(NB)) dut_u (.ref_clk, .rst, .k_in, .k_n_in,
        .load_strobe_n, .rw_sel, .burst_address_in, .dq_in, .byte_lane_write_n, .dll_enable,
        .impedance_ref_pin, .dq_out, .dq_oe, .echo_clock_true, .echo_clock_comp, .read_valid_flag,
        .impedance_code, .impedance_ready);

    initial forever #10 ref_clk = ~ref_clk;

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // write burst, expected contents tracked per byte lane
    task automatic wr(input logic [AW-1:0] a, input logic [4*DW-1:0] d, input logic [4*NB-1:0] m);
        time t;
        ctl_u.burst(1'b0, a, d, m, t);
        for (int n = 0; n < 4; n++) begin
            for (int b = 0; b < NB; b++) begin
                if (!m[n*NB+b]) begin
                    mem[AW'(a + n)][b*`BYTE_W +: `BYTE_W] = d[n*DW+b*`BYTE_W +: `BYTE_W];
                end
            end
        end
    endtask

    // read burst, latency and four beats checked, then bus release
    task automatic rd(input logic [AW-1:0] a, input time lat);
        time t;
        int w;
        ctl_u.burst(1'b1, a, '0, '0, t);
        w = 0;
        while (dq_oe !== 1'b1 && w < 40) begin
            @(negedge ref_clk);
            w++;
        end
        if (w == 40) begin
            miscompares++;
            end_sim();
        end
        `CHK("read latency", lat, $time - t)
        for (int n = 0; n < 4; n++) begin
            `CHK("read beat", mem[AW'(a + n)], dq_out)
            `CHK("read valid", 1'b1, read_valid_flag)
            repeat (4) @(negedge ref_clk);
        end
        `CHK("bus released", 1'b0, dq_oe)
    endtask

    task automatic t_reset();
        `CHK("oe after reset", 1'b0, dq_oe)
        `CHK("impedance start", 6'h20, impedance_code)
        `CHK("impedance ready", 1'b0, impedance_ready)
        $display("reset test done");
    endtask

    // latency seen at the polling edge: k cycles plus 60 ns of sync, register and poll delay
    // full write then masked overwrite, read served from the buffers
    task automatic t_buffers();
        wr(8'h10, {36'h444444444, 36'h333333333, 36'h222222222, 36'h111111111}, 16'h0000);
        wr(8'h10, {36'hddddddddd, 36'hccccccccc, 36'hbbbbbbbbb, 36'haaaaaaaaa}, 16'h0a5e);
        rd(8'h10, 380);
        $display("buffer test done");
    endtask

    // third write commits the oldest; reads never alter the array
    task automatic t_commit();
        for (int i = 1; i < 4; i++) begin
            wr(AW'(i * 32), {4{36'h13579bdf0}} ^ 144'(i * 16'h1111), 16'h0000);
        end
        rd(8'h20, 380);
        rd(8'h60, 380);
        rd(8'h10, 380);
        $display("commit test done");
    endtask

    task automatic t_nodll();
        dll_enable = 1'b0;
        repeat (16) @(negedge ref_clk);
        rd(8'h40, 220);
        dll_enable = 1'b1;
        repeat (16) @(negedge ref_clk);
        $display("dll off test done");
    endtask

    // comparator high drives the code to the top, then low turns it back
    task automatic t_imp();
        int w;
        w = 0;
        while (impedance_ready !== 1'b1 && w < 9000) begin
            @(negedge ref_clk);
            w++;
        end
        `CHK("impedance ready", 1'b1, impedance_ready)
        `CHK("impedance settled", 6'h3f, impedance_code)
        impedance_ref_pin = 1'b0;
        repeat (520) @(negedge ref_clk);
        `CHK("impedance retracks", 1'b1, impedance_code < 6'h3f)
        $display("impedance test done");
    endtask

    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_buffers();
        t_commit();
        t_nodll();
        t_imp();
        end_sim();
    end
endmodule

bind ddr_burst4_cio_sram_port sram_port_properties #(.AW(AW), .DW(DW), .NB(NB)) chk_u (.ref_clk, .rst,
    .k_in, .k_n_in, .load_strobe_n, .rw_sel, .burst_address_in, .dq_in, .byte_lane_write_n, .dll_enable,
    .impedance_ref_pin, .dq_out, .dq_oe, .echo_clock_true, .echo_clock_comp, .read_valid_flag,
    .impedance_code, .impedance_ready);

`default_nettype wire

/* sim/mem_ctl_model.sv */
// controller model: input clock pair, commands, late write data
// assumes the bench calls burst one at a time from its main process
`default_nettype none

module mem_ctl_model #(
    parameter int AW = 8,
    parameter int DW = 36,
    parameter int NB = 4
) (
    input wire logic ref_clk,
    output var logic k_in,
    output var logic k_n_in,
    output var logic load_strobe_n,
    output var logic rw_sel,
    output var logic [AW-1:0] burst_address_in,
    output var logic [DW-1:0] dq_in,
    output var logic [NB-1:0] byte_lane_write_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph = 3'h0;

    // idle levels at time zero
    initial begin
        k_in = 1'b0;
        k_n_in = 1'b1;
        load_strobe_n = 1'b1;
        rw_sel = 1'b0;
        burst_address_in = '0;
        dq_in = '0;
        byte_lane_write_n = '1;
    end

    // free-running clock pair, eight system cycles a period
    always @(negedge ref_clk) begin
        ph <= ph + 3'h1;
        k_in <= ~ph[2];
        k_n_in <= ph[2];
    end

    task automatic wait_ph(input logic [2:0] v);
        do @(negedge ref_clk); while (ph != v);
    endtask

    // one command; bus is never floated, it carries stale or inverted data outside write beats
    task automatic burst(input logic rd, input logic [AW-1:0] a, input logic [4*DW-1:0] d,
                         input logic [4*NB-1:0] m, output time t);
        wait_ph(3'h4);
        load_strobe_n = 1'b0; // load low with every command
        rw_sel = rd; // high reads, low writes
        burst_address_in = a;
        wait_ph(3'h0);
        t = $time;
        wait_ph(3'h4);
        load_strobe_n = 1'b1;
        rw_sel = ~rw_sel;
        burst_address_in = ~a;
        for (int i = 0; i < 4 && !rd; i++) begin
            wait_ph(i[0] ? 3'h2 : 3'h6);
            dq_in = d[i*DW +: DW]; // beats one cycle late, k then k-sharp
            byte_lane_write_n = m[i*NB +: NB]; // lanes ride with their beat
        end
        if (!rd) begin
            wait_ph(3'h6);
            dq_in = ~dq_in;
            byte_lane_write_n = ~byte_lane_write_n;
        end
    endtask
endmodule

`default_nettype wire

/* sim/sram_port_properties.sv */
// checker for the burst-of-four memory port, sees only the top ports
// assumes binding from the bench top; one clock domain
`default_nettype none
`include "sram_port_consts.svh"

module sram_port_properties #(
    parameter int AW = 20,
    parameter int DW = 36,
    parameter int NB = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic k_in,
    input wire logic k_n_in,
    input wire logic load_strobe_n,
    input wire logic rw_sel,
    input wire logic [AW-1:0] burst_address_in,
    input wire logic [DW-1:0] dq_in,
    input wire logic [NB-1:0] byte_lane_write_n,
    input wire logic dll_enable,
    input wire logic impedance_ref_pin,
    input wire logic [DW-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic echo_clock_true,
    input wire logic echo_clock_comp,
    input wire logic read_valid_flag,
    input wire logic [`IMP_W-1:0] impedance_code,
    input wire logic impedance_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------
    // helper counters
    // ------------------------------------------
    logic [2:0] age_q;
    logic [5:0] rd_gap_q;
    logic [13:0] up_q;

    // age since reset, gap since a read command, cycles up
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            age_q <= 3'h0;
            rd_gap_q <= 6'h3f;
            up_q <= 14'h0;
        end else begin
            age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
            rd_gap_q <= (!load_strobe_n && rw_sel) ? 6'h0 : ((rd_gap_q == 6'h3f) ? rd_gap_q : rd_gap_q + 6'h1);
            up_q <= (up_q == 14'h3fff) ? up_q : up_q + 14'h1;
        end
    end

    // ------------------------------------------
    // assertions
    // ------------------------------------------
    // two sync stages plus the output register: echo shows the pin three edges late
    a_echo_true_follows: assert property (age_q == 3'h7 |-> echo_clock_true == $past(k_in, 3))
        else $error("true echo clock off input clock timing");
    a_echo_comp_follows: assert property (age_q == 3'h7 |-> echo_clock_comp == $past(k_n_in, 3))
        else $error("complement echo clock off input clock timing");
    a_read_starts_k: assert property ($rose(dq_oe) |-> $rose(echo_clock_true))
        else $error("first read beat not on a true clock edge");
    a_read_ends_k: assert property ($fell(dq_oe) |-> $rose(echo_clock_true))
        else $error("bus released off a true clock edge");
    a_four_beats: assert property ($rose(dq_oe) |-> dq_oe [*8] ##1 dq_oe [*8])
        else $error("read burst shorter than four beats");
    a_beat_holds: assert property (dq_oe && $past(dq_oe) && !$rose(echo_clock_true)
        && !$rose(echo_clock_comp) |-> $stable(dq_out))
        else $error("read data moved between clock edges");
    a_read_has_cause: assert property ($rose(dq_oe) |-> rd_gap_q <= 6'h18)
        else $error("bus driven without a read command");
    a_imp_mid_start: assert property (disable iff (1'b0) rst |=> impedance_code == 6'h20 && !impedance_ready)
        else $error("impedance not mid range after reset");
    a_imp_one_step: assert property (!$past(rst) && $changed(impedance_code) |->
        (impedance_code - $past(impedance_code) == 6'h01) || ($past(impedance_code) - impedance_code == 6'h01))
        else $error("impedance code jumped by more than one");
    a_imp_settle_time: assert property ($rose(impedance_ready) |-> up_q >= 14'h1fa4 && up_q <= 14'h206c)
        else $error("impedance settle time off");
endmodule

`default_nettype wire

/* verilog/burst_store.sv */
// memory array with byte-masked write port and registered read port
// assumes one clock; read data hold until the next read
`default_nettype none

module burst_store #(
    parameter int AW = 20,
    parameter int DW = 36,
    parameter int NB = 4
) (
    input wire logic ref_clk,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [NB-1:0] wbe
);
    localparam int BW = DW / NB;

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_q;

    assign rdata = rdata_q;

    // byte-masked write, registered read of the old contents
    always_ff @(posedge ref_clk) begin
        if (re) begin
            rdata_q <= mem[raddr];
        end
        for (int b = 0; b < NB; b++) begin
            if (we && wbe[b]) begin
                mem[waddr][b*BW +: BW] <= wdata[b*BW +: BW];
            end
        end
    end
endmodule

`default_nettype wire

/* verilog/ddr_burst4_cio_sram_port.sv */
// device side of a double-rate common-io static memory port, bursts of four
// assumes k_in/k_n_in run far slower than ref_clk (8 samples per cycle)
// How it works
// RL1 - low byte lane writes, sampled with data
// RL2 - every access is a burst of four
// RL3 - read starts on select high at k
// RL4 - first read beat two cycles after command
// RL5 - second beat on next k_n, then alternating
// RL6 - free-running echo clocks match data timing
// RL7 - address loads only with load strobe low
// RL8 - nop keeps read going; bus floats after
// RL9 - write only every other k edge
// RL10 - controller holds load low with write
// RL11 - controller floats bus before write data; the controller model keeps driving dq_in with stale data instead
// RL12 - write data one cycle after command
// RL13 - writes buffered, committed on third write
// RL14 - reads of last two writes use buffers
// RL15 - read then write keeps newest data
// RL16 - byte masks act per burst word
// RL17 - select high never writes the array
// RL18 - impedance readjusted periodically
// RL19 - impedance starts mid, settles within 1024
// RL20 - select high reads, low writes
// RL21 - dll off gives one-cycle read latency
// RL22 - burst address counts base plus 0..3
// RL23 - bus driven only for read data
`default_nettype none
`include "sram_port_consts.svh"

module ddr_burst4_cio_sram_port #(
    parameter int AW = `ADDR_W,
    parameter int DW = `DQ_W,
    parameter int NB = `DQ_W / `BYTE_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic k_in,
    input wire logic k_n_in,
    input wire logic load_strobe_n,
    input wire logic rw_sel,
    input wire logic [AW-1:0] burst_address_in,
    input wire logic [DW-1:0] dq_in,
    input wire logic [NB-1:0] byte_lane_write_n,
    input wire logic dll_enable,
    input wire logic impedance_ref_pin,
    output logic [DW-1:0] dq_out,
    output logic dq_oe,
    output logic echo_clock_true,
    output logic echo_clock_comp,
    output logic read_valid_flag,
    output logic [`IMP_W-1:0] impedance_code,
    output logic impedance_ready
);
    localparam int BW = DW / NB;

    // ------------------------------------------------------
    // state types
    // ------------------------------------------------------
    typedef struct packed {
        logic v;
        logic [AW-1:0] base;
        logic [`BURST_LEN-1:0][NB-1:0] mask;
        logic [`BURST_LEN-1:0][DW-1:0] data;
    } entry_t;

    typedef struct packed {
        logic k1, k2, kp, kn1, kn2, knp;
        logic ld1, ld2, rw1, rw2, dll1, dll2, cmp1, cmp2;
        logic [AW-1:0] a1, a2;
        logic [DW-1:0] d1, d2;
        logic [NB-1:0] bw1, bw2;
        logic gap;
        logic pv;
        logic [AW-1:0] pa;
        logic [1:0] pw;
        logic av;
        logic [AW-1:0] aa;
        logic [1:0] ab;
        logic [AW-1:0] fa;
        logic [DW-1:0] dq;
        logic oe, ect, ecc;
        logic wcmd, wptr, wslot, cap_v;
        logic [1:0] cap_beat;
        logic [1:0][$bits(entry_t)-1:0] slot;
        entry_t cm;
        logic cm_busy;
        logic [1:0] cm_idx;
        sram_port_pkg::cal_t cal;
        logic [10:0] cal_cnt;
        logic [10:0] step_cnt;
        logic [`IMP_W-1:0] imp;
    } state_t;

    state_t s_q, s_d;
    logic mem_re, mem_we;
    logic [AW-1:0] mem_raddr, mem_waddr;
    logic [DW-1:0] mem_rdata, mem_wdata;
    logic [NB-1:0] mem_wbe;

    // ------------------------------------------------------
    // buffer merge
    // ------------------------------------------------------
    // overlay buffered bytes on array data for one address
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] w, input logic [AW-1:0] a,
                                            input entry_t e);
        logic [AW-1:0] off;
        logic [DW-1:0] r;
        r = w;
        off = a - e.base;
        if (e.v && off < AW'(`BURST_LEN)) begin
            for (int b = 0; b < NB; b++) begin
                if (e.mask[off[1:0]][b]) begin
                    r[b*BW +: BW] = e.data[off[1:0]][b*BW +: BW];
                end
            end
        end
        return r;
    endfunction

    // newest source wins: commit copy, older slot, newer slot
    function automatic logic [DW-1:0] coherent(input state_t s, input logic [DW-1:0] w,
                                               input logic [AW-1:0] a);
        logic [DW-1:0] r;
        r = merge(w, a, s.cm);
        r = merge(r, a, entry_t'(s.slot[s.wptr]));
        r = merge(r, a, entry_t'(s.slot[~s.wptr]));
        return r;
    endfunction

    // ------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------
    // one pass covering sampling, reads, writes, commit and calibration
    always_comb begin
        logic kr, knr, cmd;
        entry_t e;
        s_d = s_q;
        mem_re = 1'b0;
        mem_raddr = s_q.aa;
        mem_we = 1'b0;
        mem_waddr = s_q.cm.base + AW'(s_q.cm_idx);
        mem_wdata = s_q.cm.data[s_q.cm_idx];
        mem_wbe = s_q.cm.mask[s_q.cm_idx];
        e = entry_t'(s_q.slot[s_q.wptr]);

        // two-stage sampling of every pin
        s_d.k1 = k_in;
        s_d.k2 = s_q.k1;
        s_d.kp = s_q.k2;
        s_d.kn1 = k_n_in;
        s_d.kn2 = s_q.kn1;
        s_d.knp = s_q.kn2;
        s_d.ld1 = load_strobe_n;
        s_d.ld2 = s_q.ld1;
        s_d.rw1 = rw_sel;
        s_d.rw2 = s_q.rw1;
        s_d.dll1 = dll_enable;
        s_d.dll2 = s_q.dll1;
        s_d.cmp1 = impedance_ref_pin;
        s_d.cmp2 = s_q.cmp1;
        s_d.a1 = burst_address_in;
        s_d.a2 = s_q.a1;
        s_d.d1 = dq_in;
        s_d.d2 = s_q.d1;
        s_d.bw1 = byte_lane_write_n;
        s_d.bw2 = s_q.bw1;
        kr = s_q.k2 & ~s_q.kp;
        knr = s_q.kn2 & ~s_q.knp;

        // echo clocks follow the sampled input clocks, same stage as data
        s_d.ect = s_q.k2; // [RL6]
        s_d.ecc = s_q.kn2; // [RL6]

        // a command needs load low; the edge after a command is skipped
        cmd = kr & ~s_q.ld2 & ~s_q.gap; // [RL7] [RL9]
        if (kr) begin
            s_d.gap = cmd; // [RL9]
        end

        // array commit, one burst word per cycle
        if (s_q.cm_busy) begin
            mem_we = |s_q.cm.mask[s_q.cm_idx]; // [RL13]
            s_d.cm_idx = s_q.cm_idx + 2'h1;
            s_d.cm_busy = (s_q.cm_idx != 2'h3);
        end

        // k rising edge: even read beats, even write beats, commands
        if (kr) begin
            s_d.oe = 1'b0; // [RL8] [RL23]
            if (s_q.pv && s_q.pw == 2'h1) begin
                s_d.dq = coherent(s_q, mem_rdata, s_q.fa); // [RL4] [RL14] [RL15]
                s_d.oe = 1'b1;
                s_d.pv = 1'b0;
                s_d.av = 1'b1;
                s_d.aa = s_q.pa;
                s_d.ab = 2'h1;
                mem_re = 1'b1;
                mem_raddr = s_q.pa + AW'(1); // [RL22]
                s_d.fa = mem_raddr;
            end else if (s_q.pv) begin
                s_d.pw = s_q.pw - 2'h1;
            end
            if (s_q.av && s_q.ab == 2'h2) begin
                s_d.dq = coherent(s_q, mem_rdata, s_q.fa); // [RL5]
                s_d.oe = 1'b1;
                s_d.ab = 2'h3;
                mem_re = 1'b1;
                mem_raddr = s_q.aa + AW'(3); // [RL22]
                s_d.fa = mem_raddr;
            end
            // write beats 0 and 2 land on k
            if (s_q.wcmd) begin
                e = entry_t'(s_q.slot[s_q.wslot]);
                e.data[0] = s_q.d2; // [RL12]
                e.mask[0] = ~s_q.bw2; // [RL1] [RL16]
                s_d.slot[s_q.wslot] = e;
                s_d.wcmd = 1'b0;
                s_d.cap_v = 1'b1;
                s_d.cap_beat = 2'h1;
            end else if (s_q.cap_v && s_q.cap_beat == 2'h2) begin
                e = entry_t'(s_q.slot[s_q.wslot]);
                e.data[2] = s_q.d2;
                e.mask[2] = ~s_q.bw2; // [RL1] [RL16]
                s_d.slot[s_q.wslot] = e;
                s_d.cap_beat = 2'h3;
            end
            // new read: latency depends on the dll mode
            if (cmd && s_q.rw2) begin
                s_d.pv = 1'b1; // [RL3] [RL20]
                s_d.pa = s_q.a2;
                s_d.pw = s_q.dll2 ? `RD_LAT_DLL : `RD_LAT_NODLL; // [RL4] [RL21]
            end
            // new write: retire the oldest buffered burst first
            if (cmd && !s_q.rw2) begin
                e = entry_t'(s_q.slot[s_q.wptr]);
                if (e.v) begin
                    s_d.cm = e; // [RL13]
                    s_d.cm_busy = 1'b1;
                    s_d.cm_idx = 2'h0;
                end
                e.v = 1'b1; // [RL20]
                e.base = s_q.a2; // [RL9]
                e.mask = '0;
                s_d.slot[s_q.wptr] = e;
                s_d.wslot = s_q.wptr;
                s_d.wptr = ~s_q.wptr;
                s_d.wcmd = 1'b1; // [RL12]
            end
        end

        // k_n rising edge: odd read beats, odd write beats, first fetch
        if (knr) begin
            if (s_q.av && s_q.ab[0]) begin
                s_d.dq = coherent(s_q, mem_rdata, s_q.fa); // [RL5] [RL14]
                s_d.oe = 1'b1;
                s_d.ab = s_q.ab + 2'h1;
                s_d.av = (s_q.ab != 2'h3); // [RL2]
                if (s_q.ab == 2'h1) begin
                    mem_re = 1'b1;
                    mem_raddr = s_q.aa + AW'(2); // [RL22]
                    s_d.fa = mem_raddr;
                end
            end
            if (s_q.pv && s_q.pw == 2'h1) begin
                mem_re = 1'b1;
                mem_raddr = s_q.pa;
                s_d.fa = s_q.pa;
            end
            if (s_q.cap_v && s_q.cap_beat[0]) begin
                e = entry_t'(s_q.slot[s_q.wslot]);
                e.data[s_q.cap_beat] = s_q.d2; // [RL12]
                e.mask[s_q.cap_beat] = ~s_q.bw2; // [RL1] [RL16]
                s_d.slot[s_q.wslot] = e;
                s_d.cap_beat = s_q.cap_beat + 2'h1;
                s_d.cap_v = (s_q.cap_beat != 2'h3); // [RL2]
            end
        end

        // impedance: settle from mid code, then keep tracking
        if (kr) begin
            if (s_q.step_cnt == 11'(`CAL_STEP_KCYC - 1)) begin
                s_d.step_cnt = '0;
                if (s_q.cmp2 && s_q.imp != '1) begin
                    s_d.imp = s_q.imp + `IMP_W'(1); // [RL18]
                end else if (!s_q.cmp2 && s_q.imp != '0) begin
                    s_d.imp = s_q.imp - `IMP_W'(1); // [RL18]
                end
            end else begin
                s_d.step_cnt = s_q.step_cnt + 11'h1;
            end
            unique case (s_q.cal)
                sram_port_pkg::CAL_SETTLE: begin
                    s_d.cal_cnt = s_q.cal_cnt + 11'h1;
                    if (s_q.cal_cnt == 11'(`CAL_SETTLE_KCYC - 1)) begin
                        s_d.cal = sram_port_pkg::CAL_TRACK; // [RL19]
                    end
                end
                sram_port_pkg::CAL_TRACK: begin
                    s_d.cal_cnt = s_q.cal_cnt;
                end
            endcase
        end
    end

    // ------------------------------------------------------
    // state register
    // ------------------------------------------------------
    // synchronous reset; buffers and bus start idle, code at mid range
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.imp <= `IMP_MID; // [RL19]
            s_q.cal <= sram_port_pkg::CAL_SETTLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------
    // array and outputs
    // ------------------------------------------------------
    burst_store #(
        .AW(AW),
        .DW(DW),
        .NB(NB)
    ) u_store (
        .ref_clk(ref_clk),
        .re(mem_re),
        .raddr(mem_raddr),
        .rdata(mem_rdata),
        .we(mem_we), // [RL17]
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .wbe(mem_wbe)
    );

    // all outputs straight from the state register
    assign dq_out = s_q.dq;
    assign dq_oe = s_q.oe; // [RL23]
    assign read_valid_flag = s_q.oe;
    assign echo_clock_true = s_q.ect;
    assign echo_clock_comp = s_q.ecc;
    assign impedance_code = s_q.imp;
    assign impedance_ready = (s_q.cal == sram_port_pkg::CAL_TRACK);
endmodule

`default_nettype wire

/* verilog/sram_port_consts.svh */
// constants for the burst-of-four common-io memory port
// assumes inclusion by bare name from design, checker and bench files
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

// ----------------------------------------------------------
// bus shape
// ----------------------------------------------------------
`define DQ_W 36
`define BYTE_W 9
`define ADDR_W 20
`define BURST_LEN 4

// ----------------------------------------------------------
// read latency, in input clock cycles
// ----------------------------------------------------------
`define RD_LAT_DLL 2'h2
`define RD_LAT_NODLL 2'h1
// dll-off mode is only specified up to this input clock rate
`define NODLL_MAX_MHZ 167

// ----------------------------------------------------------
// impedance calibration
// ----------------------------------------------------------
`define IMP_W 6
`define IMP_MID 6'h20
`define CAL_SETTLE_KCYC 1024
`define CAL_STEP_KCYC (`CAL_SETTLE_KCYC / (1 << (`IMP_W - 1)))

`endif

/* verilog/sram_port_pkg.sv */
// types shared by the memory port design files
// assumes nothing of its surroundings
`default_nettype none

package sram_port_pkg;
    // impedance calibration phase
    typedef enum logic {
        CAL_SETTLE,
        CAL_TRACK
    } cal_t;
endpackage

`default_nettype wire
